// ### src/esb_pkg.sv
// Package: field layout, reset values, commands and state types of the execution-state bits
package esb_pkg;
    localparam int PSW_W = 32;
    localparam int UPPER_HI = 26;
    localparam int UPPER_LO = 25;
    localparam int STATE_BIT = 24;
    localparam int RSVD_HI_HI = 23;
    localparam int RSVD_HI_LO = 16;
    localparam int LOWER_HI = 15;
    localparam int LOWER_LO = 10;
    localparam int RSVD_LO_HI = 9;
    localparam int RSVD_LO_LO = 6;
    localparam int MAX_BLOCK_LEN = 4;
    localparam logic STATE_BIT_RST = 1'h1;
    localparam logic [7:0] EXEC_FIELD_RST = 8'h00;
    localparam logic [31:0] EXEC_VIEW_MASK = 32'h0700_FC00;

    // Access views selected by a status-register read
    typedef enum logic [2:0] {
        VIEW_FULL = 3'h0,
        VIEW_EXEC = 3'h1,
        VIEW_EXEC_INT = 3'h2,
        VIEW_APP_EXEC = 3'h3,
        VIEW_INSTR = 3'h4
    } esb_view_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RESUME = 3'b010,
        ST_BLOCK = 3'b100
    } esb_mode_e;

    // Events reported by the core pipeline; the event flags are one-cycle pulses, the other fields carry their data
    typedef struct packed {
        logic multi_interrupt;
        logic [3:0] next_reg_index;
        logic resume_done;
        logic block_start;
        logic [7:0] block_state;
        logic block_step;
        logic branch_update;
        logic [31:0] branch_target;
        logic exc_return;
        logic [31:0] stacked_status_word;
        logic vector_load;
        logic [31:0] vector_value;
    } esb_event_s;

    typedef struct packed {
        logic exec_attempt;
        logic instr_write;
        logic [31:0] instr_wdata;
        logic read_req;
        esb_view_e read_view;
    } esb_access_s;
endpackage

// ### src/esb_field_pack.sv
// Packs the stored execution state into the status-word image
module esb_field_pack (
    // Stored state
    input wire logic [7:0] exec_field,
    input wire logic state_bit,
    // Image
    output logic [31:0] image
);
    always_comb begin
        image = '0;
        image[esb_pkg::UPPER_HI:esb_pkg::UPPER_LO] = exec_field[7:6];
        image[esb_pkg::STATE_BIT] = state_bit;
        image[esb_pkg::LOWER_HI:esb_pkg::LOWER_LO] = exec_field[5:0];
    end
endmodule

// ### src/esb_block_step.sv
// Advances the conditional-block state by one covered instruction
module esb_block_step (
    // Current state
    input wire logic [7:0] cur,
    // Next state and block end
    output logic [7:0] nxt,
    output logic last
);
    always_comb begin
        // Low mask nibble shifts up; the block ends once it is empty
        nxt = {cur[7:5], cur[4:0] << 1};
        last = (cur[3:0] == 4'h8) || (cur[3:0] == 4'h0);
        if (last) begin
            nxt = 8'h00;
        end
    end
endmodule

// ### src/esb_exec_state.sv
// Execution-state bits of the program status word
// Contract
// - Continuation/conditional state is held in read-only fields 26:25 and 15:10.
// - Continuation state forces the upper split field to zero.
// - Continuation state forces the two lowest bits of the lower field zero.
// - Interrupted multi-register transfer records next register index in bits 15:12; in ST_BLOCK the code ignores multi_interrupt.
// - After servicing, transfer resumes from the register indexed by bits 15:12.
// - Conditional block covers at most four instructions after a 16-bit start.
// - Read-only instruction-set state bit 24 resets to one.
// - Branch-exchange, branch-link-exchange and stack load to pc update the state bit.
// - Exception return restores the state bit from the stacked status word.
// - Exception entry and reset load the state bit from vector bit 0; reset here sets it to one, only vector_load takes bit 0.
// - Execution with the state bit clear raises a fault instead.
// - Bits 23:16 and 9:6 are reserved, read-only, zero.
// - Execution bits are meaningful only in full or execution-state views.
// - Instruction reads of execution bits return zero; instruction writes are ignored.
// - Execution-state view maps bits 26:24 and 15:10.
module esb_exec_state (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Core events and accesses
    input esb_pkg::esb_event_s evt,
    input esb_pkg::esb_access_s acc,
    // Status outputs
    output logic [31:0] program_status_word,
    output logic [31:0] read_data,
    output logic [3:0] resume_index,
    output logic resume_valid,
    output logic block_active,
    output logic state_fault
);
    typedef struct packed {
        esb_pkg::esb_mode_e mode;
        logic [7:0] exec_field;
        logic state_bit;
        logic [31:0] psw;
        logic [31:0] rdata;
        logic [3:0] resume_idx;
        logic resume_vld;
        logic blk_act;
        logic fault;
    } esb_state_s;

    esb_state_s state_ff;
    esb_state_s nxt_state;
    logic [7:0] step_nxt;
    logic step_last;
    logic [31:0] image;

    esb_block_step u_step (
        .cur(state_ff.exec_field),
        .nxt(step_nxt),
        .last(step_last)
    );

    esb_field_pack u_pack (
        .exec_field(nxt_state.exec_field),
        .state_bit(nxt_state.state_bit),
        .image(image)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_state.fault = 1'b0;
        case (state_ff.mode)
            esb_pkg::ST_IDLE: begin
                if (evt.multi_interrupt) begin
                    nxt_state.exec_field = {2'h0, evt.next_reg_index, 2'h0};
                    nxt_state.mode = esb_pkg::ST_RESUME;
                end else if (evt.block_start) begin
                    nxt_state.exec_field = evt.block_state;
                    nxt_state.mode = esb_pkg::ST_BLOCK;
                end
            end
            esb_pkg::ST_RESUME: begin
                if (evt.resume_done) begin
                    nxt_state.exec_field = esb_pkg::EXEC_FIELD_RST;
                    nxt_state.mode = esb_pkg::ST_IDLE;
                end else if (evt.multi_interrupt) begin
                    nxt_state.exec_field = {2'h0, evt.next_reg_index, 2'h0};
                end
            end
            esb_pkg::ST_BLOCK: begin
                if (evt.block_step) begin
                    nxt_state.exec_field = step_nxt;
                    if (step_last) begin
                        nxt_state.mode = esb_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_state.mode = esb_pkg::ST_IDLE;
                nxt_state.exec_field = esb_pkg::EXEC_FIELD_RST;
            end
        endcase
        if (evt.vector_load) begin
            nxt_state.state_bit = evt.vector_value[0];
        end else if (evt.exc_return) begin
            nxt_state.state_bit = evt.stacked_status_word[esb_pkg::STATE_BIT];
        end else if (evt.branch_update) begin
            nxt_state.state_bit = evt.branch_target[0];
        end
        if (acc.exec_attempt && !state_ff.state_bit) begin
            nxt_state.fault = 1'b1;
        end
        nxt_state.resume_idx = nxt_state.exec_field[5:2];
        nxt_state.resume_vld = (nxt_state.mode == esb_pkg::ST_RESUME);
        nxt_state.blk_act = (nxt_state.mode == esb_pkg::ST_BLOCK);
        nxt_state.psw = image;
        // Writes by instruction have no path into this state
        // instruction writes ignored
        if (acc.read_req) begin
            case (acc.read_view)
                esb_pkg::VIEW_FULL, esb_pkg::VIEW_EXEC: begin
                    nxt_state.rdata = state_ff.psw & esb_pkg::EXEC_VIEW_MASK;
                end
                default: begin
                    nxt_state.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff.mode <= esb_pkg::ST_IDLE;
            state_ff.exec_field <= esb_pkg::EXEC_FIELD_RST;
            state_ff.state_bit <= esb_pkg::STATE_BIT_RST;
            state_ff.psw <= 32'h0100_0000;
            state_ff.rdata <= 32'h0000_0000;
            state_ff.resume_idx <= 4'h0;
            state_ff.resume_vld <= 1'b0;
            state_ff.blk_act <= 1'b0;
            state_ff.fault <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign program_status_word = state_ff.psw;
    assign read_data = state_ff.rdata;
    assign resume_index = state_ff.resume_idx;
    assign resume_valid = state_ff.resume_vld;
    assign block_active = state_ff.blk_act;
    assign state_fault = state_ff.fault;
endmodule

// ### tb/esb_exec_state_assertions.sv
// Checker for the execution-state bits
module esb_exec_state_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Core side
    input esb_pkg::esb_event_s evt,
    input esb_pkg::esb_access_s acc,
    // Status outputs
    input wire logic [31:0] program_status_word,
    input wire logic [31:0] read_data,
    input wire logic [3:0] resume_index,
    input wire logic resume_valid,
    input wire logic block_active,
    input wire logic state_fault
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_rsvd; (program_status_word & 32'hF8FF_03FF) == 32'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_cont; resume_valid |-> program_status_word[26:25] == 2'h0 && program_status_word[11:10] == 2'h0;
    endproperty
    a_cont: assert property (p_cont) else $error("continuation form broken");
    property p_idx; evt.multi_interrupt && !evt.resume_done && !block_active
        |=> resume_valid && resume_index == $past(evt.next_reg_index);
    endproperty
    a_idx: assert property (p_idx) else $error("resume index not recorded");
    property p_res; resume_valid |-> program_status_word[15:12] == resume_index; endproperty
    a_res: assert property (p_res) else $error("resume index not in image");
    property p_done; resume_valid && evt.resume_done && !evt.multi_interrupt |=> !resume_valid
        && (program_status_word & 32'h0600_FC00) == 32'h0; endproperty
    a_done: assert property (p_done) else $error("field not cleared");
    property p_vec; evt.vector_load |=> program_status_word[24] == $past(evt.vector_value[0]); endproperty
    a_vec: assert property (p_vec) else $error("vector bit not loaded");
    property p_exc; evt.exc_return && !evt.vector_load |=> program_status_word[24] == $past(evt.stacked_status_word[24]);
    endproperty
    a_exc: assert property (p_exc) else $error("stacked bit not restored");
    property p_hold; !(evt.vector_load || evt.exc_return || evt.branch_update) |=> $stable(program_status_word[24]);
    endproperty
    a_hold: assert property (p_hold) else $error("state bit moved");
    property p_fault; state_fault == $past(acc.exec_attempt && !program_status_word[24]); endproperty
    a_fault: assert property (p_fault) else $error("fault pulse wrong");
    property p_read; acc.read_req |=> read_data == ($past(acc.read_view inside {esb_pkg::VIEW_FULL,
        esb_pkg::VIEW_EXEC}) ? $past(program_status_word) & esb_pkg::EXEC_VIEW_MASK : 32'h0); endproperty
    a_read: assert property (p_read) else $error("read data wrong");
    c_resume: cover property (evt.multi_interrupt);
    c_fault: cover property (state_fault);
    c_step: cover property (block_active && evt.block_step);
endmodule

bind esb_exec_state esb_exec_state_assertions u_chk (.sys_clk, .reset_n, .evt, .acc, .program_status_word,
    .read_data, .resume_index, .resume_valid, .block_active, .state_fault);

// ### tb/tb_top.sv
// Self-checking bench for the execution-state bits
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    esb_pkg::esb_event_s ev = '0;
    esb_pkg::esb_access_s ac = '0;
    logic [31:0] psw, rd;
    logic [3:0] ridx;
    logic rv, ba, sf;
    int n_fail = 0;
    int comparisons = 0;
    always #5 sys_clk = ~sys_clk;
    esb_exec_state dut (.sys_clk(sys_clk), .reset_n(reset_n), .evt(ev), .acc(ac), .program_status_word(psw),
        .read_data(rd), .resume_index(ridx), .resume_valid(rv), .block_active(ba), .state_fault(sf));
    // One pulse, outputs settled on return
    task automatic send(input esb_pkg::esb_event_s e, input esb_pkg::esb_access_s a);
        @(posedge sys_clk);
        ev <= e;
        ac <= a;
        @(posedge sys_clk);
        ev <= '0;
        ac <= '0;
        #1;
    endtask
    task automatic t_resume();
        esb_pkg::esb_event_s e;
        esb_pkg::esb_access_s a;
        e = '0;
        e.multi_interrupt = 1'b1;
        e.next_reg_index = 4'hF;
        send(e, '0);
        `CHK("idx", 4'hF, ridx)
        `CHK("rv", 1'b1, rv)
        `CHK("psw", 32'h0100_F000, psw)
        // Every view, only two carry data
        for (int i = 0; i < 5; i++) begin
            a = '0;
            a.read_req = 1'b1;
            a.read_view = esb_pkg::esb_view_e'(3'(i));
            send('0, a);
            `CHK("rd", (i < 2) ? 32'h0100_F000 : 32'h0, rd)
        end
        a = '0;
        a.instr_write = 1'b1;
        a.instr_wdata = 32'hFFFF_FFFF;
        send('0, a);
        `CHK("wr", 32'h0100_F000, psw)
        // Second interrupt while suspended records a new index
        e = '0;
        e.multi_interrupt = 1'b1;
        e.next_reg_index = 4'h5;
        send(e, '0);
        `CHK("reidx", 33'h1_0100_5000, {rv, psw})
        e = '0;
        e.resume_done = 1'b1;
        send(e, '0);
        `CHK("done", 33'h0_0100_0000, {rv, psw})
        $display("resume test done");
    endtask
    task automatic t_block();
        esb_pkg::esb_event_s e;
        e = '0;
        e.block_start = 1'b1;
        e.block_state = 8'h01;
        send(e, '0);
        `CHK("start", 32'h0100_0400, psw)
        e = '0;
        e.block_step = 1'b1;
        // Four covered instructions
        for (int i = 0; i < 4; i++) begin
            `CHK("act", 1'b1, ba)
            send(e, '0);
        end
        `CHK("end", 33'h0_0100_0000, {ba, psw})
        $display("block test done");
    endtask
    task automatic t_state();
        esb_pkg::esb_event_s e;
        esb_pkg::esb_access_s a;
        e = '0;
        e.vector_load = 1'b1;
        send(e, '0);
        `CHK("vec", 1'b0, psw[24])
        a = '0;
        a.exec_attempt = 1'b1;
        send('0, a);
        `CHK("fault", 1'b1, sf)
        e = '0;
        e.exc_return = 1'b1;
        e.stacked_status_word = 32'h0100_0000;
        send(e, '0);
        `CHK("exc", 1'b1, psw[24])
        e = '0;
        e.branch_update = 1'b1;
        send(e, '0);
        `CHK("br", 1'b0, psw[24])
        e.vector_load = 1'b1;
        e.vector_value = 32'h1;
        send(e, '0);
        `CHK("prio", 1'b1, psw[24])
        send('0, a);
        `CHK("nofault", 1'b0, sf)
        $display("state bit test done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        `CHK("rst", 32'h0100_0000, psw)
        t_resume();
        t_block();
        t_state();
        complete_run();
    end
    // Tests need under fifty cycles
    initial begin
        #50000;
        n_fail++;
        complete_run();
    end
endmodule
